// file: ctrl_port_pkg.sv
/*
  Constants shared by the debugger-side control access port register bank:
  register offsets, field positions, reset values and erase-walk states.
  Assumes a 32-bit register data path and byte offsets on an 8-bit address.
*/
`default_nettype none

package ctrl_port_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFS_SYSTEM_RESET_REQUEST   = 8'h00;
  localparam logic [7:0] OFS_WHOLE_ERASE_TRIGGER    = 8'h04;
  localparam logic [7:0] OFS_WHOLE_ERASE_PROGRESS   = 8'h08;
  localparam logic [7:0] OFS_NONSECURE_GUARD_KEY    = 8'h10;
  localparam logic [7:0] OFS_SECURE_GUARD_KEY       = 8'h14;
  localparam logic [7:0] OFS_ERASE_GUARD_STATE      = 8'h18;
  localparam logic [7:0] OFS_ERASE_GUARD_KEY        = 8'h1C;
  localparam logic [7:0] OFS_MAILBOX_TO_CPU_WORD    = 8'h20;
  localparam logic [7:0] OFS_MAILBOX_TO_CPU_FLAG    = 8'h24;
  localparam logic [7:0] OFS_MAILBOX_FROM_CPU_WORD  = 8'h28;
  localparam logic [7:0] OFS_MAILBOX_FROM_CPU_FLAG  = 8'h2C;
  localparam logic [7:0] OFS_PORT_IDENTIFICATION    = 8'hFC;

  // Field positions
  localparam int TRIGGER_BIT     = 0;
  localparam int IDR_REV_LSB     = 28;
  localparam int IDR_CONT_LSB    = 24;
  localparam int IDR_MAKER_LSB   = 17;
  localparam int IDR_CLASS_LSB   = 13;
  localparam int IDR_PORT_IDENTITY_FIELD_LSB    = 0;

  // Values
  localparam logic [31:0] RESET_WORD         = 32'h0000_0000;
  localparam logic [31:0] NO_KEY             = 32'h0000_0000;
  localparam logic        PENDING_VALUE      = 1'b1;
  localparam logic        NOT_PENDING_VALUE  = 1'b0;
  localparam logic        PROGRESS_BUSY      = 1'b1;
  localparam logic        PROGRESS_IDLE      = 1'b0;
  localparam logic [3:0]  MEMORY_PORT_CLASS  = 4'h8;

  // Mailbox buffer
  localparam int MAILBOX_DEPTH = 4;

  // Erase walk: flash, then SRAM, then user configuration area
  typedef enum logic [3:0] {
    ERASE_IDLE   = 4'b0001,
    ERASE_FLASH  = 4'b0010,
    ERASE_SRAM   = 4'b0100,
    ERASE_CONFIG = 4'b1000
  } erase_state_e;

endpackage

`default_nettype wire

// file: ctrl_port_regs.sv
/*
  Debugger-only register bank of the control access port, with a small
  mailbox FIFO toward the CPU.
  Assumes the debug port logic hands over decoded register accesses on
  ref_clk, and that erase engines, key registers of the firmware side and
  the user configuration area all live on the same clock.
*/
// Summary of operation
// - Bank reachable by debugger only, never CPU
// - Secure guard acts only with secure extension
// - Writing reset register requests system reset
// - Reset request ignored while erase runs
// - Erase trigger clears flash, SRAM, config
// - Factory defaults at reset after erase
// - Erase progress register readable by debugger
// - Matching nonsecure key lifts nonsecure guard
// - Matching secure key lifts secure guard
// - Erase guard setting reported read-only
// - Matching erase key removes guard, erases
// - Outgoing word write sets pending flag
// - Outgoing flag shows word unread or read
// - Incoming word read clears pending flag
// - Incoming flag shows word pending or read
// - Read-only identification register with fields
// - Progress busy throughout erase, else idle
// - Both sides same non-zero key required
// - Outgoing write sets out flag; incoming read clears in flag
`timescale 1ns/1ps
`default_nettype none

module mailbox_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [PTR_W:0]              count;
  } fifo_s;

  fifo_s state;
  fifo_s next_state;
  logic  push;
  logic  pop;

  // Count tells full from empty; pointers wrap at DEPTH
  assign in_ready  = (state.count != (PTR_W+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = state.mem[state.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_state = state;
    // Write side first, then read side
    if (push)
    begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr = (state.wr_ptr == PTR_W'(DEPTH - 1)) ? '0
                          : state.wr_ptr + PTR_W'(1);
    end
    if (pop)
    begin
      next_state.rd_ptr = (state.rd_ptr == PTR_W'(DEPTH - 1)) ? '0
                          : state.rd_ptr + PTR_W'(1);
    end
    if (push && !pop)
    begin
      next_state.count = state.count + (PTR_W+1)'(1);
    end
    else if (pop && !push)
    begin
      next_state.count = state.count - (PTR_W+1)'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule // mailbox_fifo

module ctrl_port_regs #(
  parameter int         MAILBOX_DEPTH = ctrl_port_pkg::MAILBOX_DEPTH,
  // Identification fields; values are arbitrary
  parameter logic [3:0] ID_REVISION   = 4'h1,
  parameter logic [3:0] ID_MAKER_CONT = 4'h0,
  parameter logic [6:0] ID_MAKER_CODE = 7'h00,
  parameter logic [7:0] ID_PORT       = 8'h00
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Debugger register access
  input  wire logic        dbg_req,
  input  wire logic        dbg_write,
  input  wire logic [7:0]  dbg_addr,
  input  wire logic [31:0] dbg_wdata,
  output logic             dbg_ack,
  output logic [31:0]      dbg_rdata,
  // Firmware-side keys and configuration
  input  wire logic [31:0] cpu_nonsecure_key,
  input  wire logic [31:0] cpu_secure_key,
  input  wire logic [31:0] cpu_erase_key,
  input  wire logic        secure_extension,
  input  wire logic        erase_guard_enabled,
  // Guard and reset outputs
  output logic             nonsecure_guard_lifted,
  output logic             secure_guard_lifted,
  output logic             system_reset_req,
  output logic             factory_default_pending,
  // Erase engines
  output logic             erase_flash_req,
  output logic             erase_sram_req,
  output logic             erase_config_req,
  input  wire logic        erase_step_done,
  // Mailbox toward CPU
  output logic             cpu_mbox_valid,
  output logic [31:0]      cpu_mbox_word,
  input  wire logic        cpu_mbox_take,
  output logic             mailbox_out_flag,
  // Mailbox from CPU
  input  wire logic        cpu_mbox_write,
  input  wire logic [31:0] cpu_mbox_wdata,
  output logic             mailbox_in_flag
);

  // Bank state apart from the mailbox FIFO, registered in one process
  typedef struct packed {
    logic                        ack;
    logic [31:0]                 rdata;
    logic                        reset_bit;
    logic                        reset_pulse;
    logic [31:0]                 ns_key;
    logic [31:0]                 s_key;
    logic [31:0]                 e_key;
    logic                        ns_lifted;
    logic                        s_lifted;
    logic                        e_key_used;
    ctrl_port_pkg::erase_state_e erase;
    logic                        factory;
    logic                        cpu_valid;
    logic [31:0]                 cpu_word;
    logic [31:0]                 in_word;
    logic                        in_flag;
  } regs_s;

  regs_s       state;
  regs_s       next_state;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic        fifo_out_ready;
  logic        wr;
  logic        rd;
  logic        erase_busy;
  logic        e_key_match;
  logic        start_erase;

  // Only debugger accesses decode here; no CPU address path exists
  assign wr = dbg_req && dbg_write && !state.ack;
  assign rd = dbg_req && !dbg_write && !state.ack;
  // Any erase step running
  assign erase_busy = (state.erase != ctrl_port_pkg::ERASE_IDLE);

  assign fifo_in_valid  = wr &&
                          (dbg_addr == ctrl_port_pkg::OFS_MAILBOX_TO_CPU_WORD);
  assign fifo_out_ready = !state.cpu_valid || cpu_mbox_take;

  // Both sides must hold the same non-zero key
  assign e_key_match = (state.e_key != ctrl_port_pkg::NO_KEY) &&
                       (state.e_key == cpu_erase_key);

  // Plain trigger when unguarded, or key unlock of the guard
  assign start_erase = !erase_busy &&
    ((wr && dbg_addr == ctrl_port_pkg::OFS_WHOLE_ERASE_TRIGGER &&
      dbg_wdata[ctrl_port_pkg::TRIGGER_BIT] && !erase_guard_enabled) ||
     (e_key_match && !state.e_key_used));

  mailbox_fifo #(
    .WIDTH (32),
    .DEPTH (MAILBOX_DEPTH)
  ) u_to_cpu (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_data   (dbg_wdata),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  always_comb
  begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.reset_pulse = 1'b0;

    // Read data loads with the one-cycle ack
    if (rd)
    begin
      next_state.ack = 1'b1;
      unique case (dbg_addr)
        ctrl_port_pkg::OFS_SYSTEM_RESET_REQUEST:
          next_state.rdata = {31'h0, state.reset_bit};
        ctrl_port_pkg::OFS_WHOLE_ERASE_PROGRESS:
          next_state.rdata = {31'h0, erase_busy ?
            ctrl_port_pkg::PROGRESS_BUSY : ctrl_port_pkg::PROGRESS_IDLE};
        ctrl_port_pkg::OFS_NONSECURE_GUARD_KEY:
          next_state.rdata = state.ns_key;
        ctrl_port_pkg::OFS_SECURE_GUARD_KEY:
          next_state.rdata = state.s_key;
        ctrl_port_pkg::OFS_ERASE_GUARD_STATE:
          next_state.rdata = {31'h0, erase_guard_enabled};
        ctrl_port_pkg::OFS_ERASE_GUARD_KEY:
          next_state.rdata = state.e_key;
        ctrl_port_pkg::OFS_MAILBOX_TO_CPU_FLAG:
          next_state.rdata = {31'h0, fifo_out_valid || state.cpu_valid};
        ctrl_port_pkg::OFS_MAILBOX_FROM_CPU_WORD:
          next_state.rdata = state.in_word;
        ctrl_port_pkg::OFS_MAILBOX_FROM_CPU_FLAG:
          next_state.rdata = {31'h0, state.in_flag};
        ctrl_port_pkg::OFS_PORT_IDENTIFICATION:
          next_state.rdata = {ID_REVISION, ID_MAKER_CONT, ID_MAKER_CODE,
                              ctrl_port_pkg::MEMORY_PORT_CLASS, 5'h00,
                              ID_PORT};
        default:
          next_state.rdata = ctrl_port_pkg::RESET_WORD;
      endcase
    end

    if (wr)
    begin
      // Outgoing word stalls until the buffer has room
      next_state.ack = !fifo_in_valid || fifo_in_ready;
      unique case (dbg_addr)
        ctrl_port_pkg::OFS_SYSTEM_RESET_REQUEST:
        begin
          if (!erase_busy)
          begin
            next_state.reset_bit = dbg_wdata[ctrl_port_pkg::TRIGGER_BIT];
            next_state.reset_pulse =
              dbg_wdata[ctrl_port_pkg::TRIGGER_BIT];
          end
        end
        ctrl_port_pkg::OFS_NONSECURE_GUARD_KEY:
          next_state.ns_key = dbg_wdata;
        ctrl_port_pkg::OFS_SECURE_GUARD_KEY:
          next_state.s_key = dbg_wdata;
        ctrl_port_pkg::OFS_ERASE_GUARD_KEY:
        begin
          next_state.e_key = dbg_wdata;
          next_state.e_key_used = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Key comparison for both access guards
    next_state.ns_lifted = (state.ns_key != ctrl_port_pkg::NO_KEY) &&
                           (state.ns_key == cpu_nonsecure_key);
    next_state.s_lifted  = secure_extension &&
                           (state.s_key != ctrl_port_pkg::NO_KEY) &&
                           (state.s_key == cpu_secure_key);

    // Erase walk in order flash, SRAM, configuration
    unique case (state.erase)
      ctrl_port_pkg::ERASE_IDLE:
        if (start_erase)
        begin
          next_state.erase = ctrl_port_pkg::ERASE_FLASH;
          next_state.e_key_used = e_key_match;
        end
      ctrl_port_pkg::ERASE_FLASH:
        if (erase_step_done)
          next_state.erase = ctrl_port_pkg::ERASE_SRAM;
      ctrl_port_pkg::ERASE_SRAM:
        if (erase_step_done)
          next_state.erase = ctrl_port_pkg::ERASE_CONFIG;
      ctrl_port_pkg::ERASE_CONFIG:
        if (erase_step_done)
        begin
          next_state.erase = ctrl_port_pkg::ERASE_IDLE;
          next_state.factory = 1'b1;
        end
      default:
        next_state.erase = ctrl_port_pkg::ERASE_IDLE;
    endcase

    // Mailbox toward CPU: staged word for the CPU side
    if (fifo_out_valid && fifo_out_ready)
    begin
      next_state.cpu_valid = 1'b1;
      next_state.cpu_word  = fifo_out_data;
    end
    else if (cpu_mbox_take)
    begin
      next_state.cpu_valid = 1'b0;
    end

    // Mailbox from CPU; a new CPU word wins over a clearing read
    if (rd && dbg_addr == ctrl_port_pkg::OFS_MAILBOX_FROM_CPU_WORD)
    begin
      next_state.in_flag = ctrl_port_pkg::NOT_PENDING_VALUE;
    end
    if (cpu_mbox_write)
    begin
      next_state.in_flag = ctrl_port_pkg::PENDING_VALUE;
      next_state.in_word = cpu_mbox_wdata;
    end
  end

  // Reset leaves the erase walk idle and all outputs low
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state       <= '0;
      state.erase <= ctrl_port_pkg::ERASE_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Every output comes straight from a state flop
  assign dbg_ack                 = state.ack;
  assign dbg_rdata               = state.rdata;
  assign nonsecure_guard_lifted  = state.ns_lifted;
  assign secure_guard_lifted     = state.s_lifted;
  assign system_reset_req        = state.reset_pulse;
  assign factory_default_pending = state.factory;
  // One-hot state bits drive the erase requests directly
  assign erase_flash_req         = state.erase[1];
  assign erase_sram_req          = state.erase[2];
  assign erase_config_req        = state.erase[3];
  assign cpu_mbox_valid          = state.cpu_valid;
  assign cpu_mbox_word           = state.cpu_word;
  // Pending while a staged word waits for the CPU to take it
  assign mailbox_out_flag        = state.cpu_valid;
  assign mailbox_in_flag         = state.in_flag;

endmodule // ctrl_port_regs

`default_nettype wire

// file: ctrl_port_regs_assertions.sv
/*
  Checker for the control access port register bank.
  Assumes rising-edge ref_clk and active-high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_checker (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Debugger access
  input wire logic        dbg_req,
  input wire logic        dbg_write,
  input wire logic [7:0]  dbg_addr,
  input wire logic [31:0] dbg_wdata,
  input wire logic        dbg_ack,
  // Device side
  input wire logic        secure_extension,
  input wire logic        erase_guard_enabled,
  input wire logic        secure_guard_lifted,
  input wire logic        system_reset_req,
  input wire logic        factory_default_pending,
  input wire logic        erase_flash_req,
  input wire logic        erase_sram_req,
  input wire logic        erase_config_req,
  input wire logic        erase_step_done,
  input wire logic        cpu_mbox_write,
  input wire logic        mailbox_in_flag,
  input wire logic        mailbox_out_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic busy;
  logic set0;
  logic rd_ack;
  assign busy = erase_flash_req | erase_sram_req | erase_config_req;
  assign set0 = dbg_req & ~dbg_ack & dbg_write & dbg_wdata[0];
  assign rd_ack = dbg_ack & ~dbg_write;
  AST_RESET_REQ: assert property (
    set0 && dbg_addr == 8'h00 && !busy |=> system_reset_req)
    else $error("reset request not issued");
  AST_RESET_MASKED: assert property (
    set0 && dbg_addr == 8'h00 && busy |=> !system_reset_req)
    else $error("reset request during erase");
  AST_ERASE_START: assert property (
    set0 && dbg_addr == 8'h04 && !busy && !erase_guard_enabled
    |=> erase_flash_req)
    else $error("erase did not start");
  AST_ERASE_ONEHOT: assert property (
    $onehot0({erase_flash_req, erase_sram_req, erase_config_req}))
    else $error("two erase steps at once");
  AST_ERASE_ORDER: assert property (
    erase_flash_req && erase_step_done |=> erase_sram_req)
    else $error("sram step not after flash");
  AST_ERASE_END: assert property (
    erase_config_req && erase_step_done
    |=> !busy && factory_default_pending)
    else $error("erase end wrong");
  AST_SECURE_EXT: assert property (
    secure_guard_lifted |-> $past(secure_extension))
    else $error("secure guard lifted without extension");
  AST_IN_FLAG: assert property (
    cpu_mbox_write |=> mailbox_in_flag)
    else $error("incoming flag not set");
  AST_IN_CLEAR: assert property (
    rd_ack && dbg_addr == 8'h28 && !cpu_mbox_write
    && !$past(cpu_mbox_write) |=> !mailbox_in_flag)
    else $error("incoming flag not cleared");
  AST_OUT_FLAG: assert property (
    dbg_ack && dbg_write && dbg_addr == 8'h20 |=> mailbox_out_flag)
    else $error("outgoing flag not set");
  cover property (erase_config_req && erase_step_done);
  cover property (dbg_ack && dbg_write && dbg_addr == 8'h20);
  cover property (secure_guard_lifted);
endmodule // ctrl_port_checker

bind ctrl_port_regs ctrl_port_checker chk_u (
  .ref_clk, .reset, .dbg_req, .dbg_write, .dbg_addr, .dbg_wdata,
  .dbg_ack, .secure_extension, .erase_guard_enabled,
  .secure_guard_lifted, .system_reset_req, .factory_default_pending,
  .erase_flash_req, .erase_sram_req, .erase_config_req,
  .erase_step_done, .cpu_mbox_write, .mailbox_in_flag,
  .mailbox_out_flag);
`default_nettype wire

// file: debug_probe.sv
/*
  Debug probe model issuing register accesses.
  Assumes the bench calls xfer; lines change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_probe (
  // Clock
  input wire logic        ref_clk,
  // Register access
  output var logic        dbg_req,
  output var logic        dbg_write,
  output var logic [7:0]  dbg_addr,
  output var logic [31:0] dbg_wdata,
  input wire logic        dbg_ack
);
  initial
  begin
    dbg_req = 1'b0;
    dbg_write = 1'b0;
    dbg_addr = 8'h00;
    dbg_wdata = 32'h0;
  end
  // Holds through the edge that samples ack, then scrambles idle lines
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(negedge ref_clk);
    dbg_req = 1'b1;
    dbg_write = w;
    dbg_addr = a;
    dbg_wdata = d;
    @(negedge ref_clk);
    while (dbg_ack !== 1'b1)
      @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    dbg_req = 1'b0;
    dbg_addr = ~a;
    dbg_wdata = ~d;
  endtask
endmodule // debug_probe
`default_nettype wire

// file: ctrl_port_regs_test.sv
/*
  Self-checking bench for the control access port register bank.
  Assumes the probe model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module ctrl_port_regs_test;
  localparam logic [31:0] ID_WORD = {4'h3, 4'h2, 7'h15, 4'h8, 13'hA5};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic dbg_req, dbg_write, dbg_ack;
  logic [7:0] dbg_addr;
  logic [31:0] dbg_wdata, dbg_rdata, cpu_mbox_word, cpu_mbox_wdata, k;
  logic [31:0] cpu_nonsecure_key, cpu_secure_key, cpu_erase_key;
  logic secure_extension, erase_guard_enabled, nonsecure_guard_lifted;
  logic secure_guard_lifted, system_reset_req, factory_default_pending;
  logic erase_flash_req, erase_sram_req, erase_config_req;
  logic erase_step_done, cpu_mbox_valid, cpu_mbox_take;
  logic mailbox_out_flag, cpu_mbox_write, mailbox_in_flag;
  logic [1:0] lifted;
  logic [63:0] rexp;
  logic [63:0] rdq[$];
  logic [31:0] mq[$];
  int err_count, n_checks, pulses, cyc;

  always #5 ref_clk = ~ref_clk;
  assign lifted = {nonsecure_guard_lifted, secure_guard_lifted};

  debug_probe probe_u (.ref_clk, .dbg_req, .dbg_write, .dbg_addr,
    .dbg_wdata, .dbg_ack);
  ctrl_port_regs #(.ID_REVISION(4'h3), .ID_MAKER_CONT(4'h2),
    .ID_MAKER_CODE(7'h15), .ID_PORT(8'hA5)) dut_u (.ref_clk, .reset,
    .dbg_req, .dbg_write, .dbg_addr, .dbg_wdata, .dbg_ack, .dbg_rdata,
    .cpu_nonsecure_key, .cpu_secure_key, .cpu_erase_key,
    .secure_extension, .erase_guard_enabled, .nonsecure_guard_lifted,
    .secure_guard_lifted, .system_reset_req, .factory_default_pending,
    .erase_flash_req, .erase_sram_req, .erase_config_req,
    .erase_step_done, .cpu_mbox_valid, .cpu_mbox_word, .cpu_mbox_take,
    .mailbox_out_flag, .cpu_mbox_write, .cpu_mbox_wdata,
    .mailbox_in_flag);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Result watcher
  always @(posedge ref_clk)
  begin
    cyc++;
    if (system_reset_req === 1'b1)
      pulses++;
    if (dbg_ack === 1'b1 && dbg_write === 1'b0)
    begin
      rexp = rdq.pop_front();
      `CHK(dbg_rdata & rexp[63:32], rexp[31:0])
    end
    if (cpu_mbox_take === 1'b1 && cpu_mbox_valid === 1'b1)
    begin
      rexp[31:0] = mq.pop_front();
      `CHK(cpu_mbox_word, rexp[31:0])
    end
    if (cyc == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    rdq.push_back({m, e});
    probe_u.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    probe_u.xfer(1'b1, a, d);
  endtask

  task automatic walk();
    logic [2:0] st;
    st = 3'b100;
    repeat (3)
    begin
      `CHK({erase_flash_req, erase_sram_req, erase_config_req}, st)
      @(negedge ref_clk) erase_step_done = 1'b1;
      @(negedge ref_clk) erase_step_done = 1'b0;
      st = st >> 1;
    end
    `CHK({erase_flash_req, factory_default_pending}, 2'b01)
  endtask

  initial
  begin
    void'($urandom(42073));
    {cpu_nonsecure_key, cpu_secure_key, cpu_erase_key} = '0;
    {cpu_mbox_wdata, secure_extension, erase_guard_enabled} = '0;
    {erase_step_done, cpu_mbox_take, cpu_mbox_write} = '0;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    rd(8'h08, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h2C, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'hFC, ID_WORD);
    `CHK({nonsecure_guard_lifted, secure_guard_lifted}, 2'b00)
    $display("test identity done");
    wr(8'h00, 32'h1);
    `CHK(pulses, 1)
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h1, 32'h1);
    wr(8'h00, 32'h1);
    `CHK(pulses, 1)
    walk();
    rd(8'h08, 32'h0, 32'h1);
    $display("test erase done");
    erase_guard_enabled = 1'b1;
    rd(8'h18, 32'h1);
    wr(8'h04, 32'h1);
    `CHK(erase_flash_req, 1'b0)
    k = $urandom | 32'h1;
    cpu_erase_key = k;
    wr(8'h1C, k);
    walk();
    $display("test erase guard done");
    for (int i = 0; i < 4; i++)
    begin
      k = $urandom | 32'h1;
      secure_extension = i[1];
      cpu_nonsecure_key = k;
      cpu_secure_key = k;
      wr(8'h10, i[0] ? k : ~k);
      wr(8'h14, i[0] ? k : ~k);
      rd(8'h14, i[0] ? k : ~k);
      `CHK(lifted, {i[0], i[0] & i[1]})
    end
    $display("test guards done");
    k = $urandom;
    @(negedge ref_clk) cpu_mbox_write = 1'b1;
    cpu_mbox_wdata = k;
    @(negedge ref_clk) cpu_mbox_write = 1'b0;
    `CHK(mailbox_in_flag, 1'b1)
    rd(8'h2C, 32'h1);
    rd(8'h28, k);
    `CHK(mailbox_in_flag, 1'b0)
    rd(8'h2C, 32'h0);
    $display("test mailbox in done");
    for (int i = 0; i < 6; i++)
    begin
      k = $urandom;
      mq.push_back(k);
      if (i == 5)
        rd(8'h24, 32'h1);
      fork
        wr(8'h20, k);
        if (i == 5)
        begin
          repeat (6) @(negedge ref_clk);
          `CHK(dbg_req, 1'b1)
          `CHK(mailbox_out_flag, 1'b1)
          repeat (8)
          begin
            @(negedge ref_clk) cpu_mbox_take = cpu_mbox_valid;
            @(negedge ref_clk) cpu_mbox_take = 1'b0;
          end
        end
      join
    end
    `CHK(mq.size(), 0)
    `CHK(mailbox_out_flag, 1'b0)
    rd(8'h24, 32'h0);
    $display("test mailbox out done");
    report_and_stop();
  end
endmodule // ctrl_port_regs_test
`default_nettype wire
